// ---- src/hcd_pkg.sv ----
package hcd_pkg;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ID_W   = 16;
  localparam int unsigned DLY_W  = 21;

  // ****************************************************
  // image byte offsets
  // ****************************************************
  localparam logic [3:0] OFS_PID_LO  = 4'h2;
  localparam logic [3:0] OFS_PID_HI  = 4'h3;
  localparam logic [3:0] OFS_DID_LO  = 4'h4;
  localparam logic [3:0] OFS_DID_HI  = 4'h5;
  localparam logic [3:0] OFS_OPT1    = 4'h6;
  localparam logic [3:0] OFS_OPT2    = 4'h7;
  localparam logic [3:0] OFS_FIXED   = 4'h8;
  localparam logic [3:0] OFS_PDIS_SP = 4'h9;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int unsigned OPT1_PWR    = 7;
  localparam int unsigned OPT1_LED    = 6;
  localparam int unsigned OPT1_FSO    = 5;
  localparam int unsigned OPT1_MTT    = 4;
  localparam int unsigned OPT1_EOP    = 3;
  localparam int unsigned OPT1_OCS_HI = 2;
  localparam int unsigned OPT1_OCS_LO = 1;
  localparam int unsigned OPT1_PSW    = 0;
  localparam int unsigned OPT2_DYN    = 7;
  localparam int unsigned OPT2_OCT_HI = 5;
  localparam int unsigned OPT2_OCT_LO = 4;
  localparam int unsigned OPT2_CMP    = 3;
  localparam int unsigned MASK_RSVD   = 0;

  // ****************************************************
  // reset values and codes
  // ****************************************************
  localparam logic [7:0]  RST_OPT1_SELF = 8'h98;
  localparam logic [7:0]  RST_OPT2_SELF = 8'h10;
  localparam logic [7:0]  RST_OPT1_BUS  = 8'h1C;
  localparam logic [7:0]  RST_OPT2_BUS  = 8'h90;
  localparam logic [7:0]  RST_MASK      = 8'h00;
  localparam logic [15:0] RST_DID       = 16'h0000;
  localparam logic [7:0]  RD_NONE       = 8'h00;
  localparam logic [1:0]  OCT_0P1       = 2'h0;
  localparam logic [1:0]  OCT_2         = 2'h1;
  localparam logic [1:0]  OCT_4         = 2'h2;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned OC_T0_US      = 100;
  localparam int unsigned OC_T1_US      = 2000;
  localparam int unsigned OC_T2_US      = 4000;
  localparam int unsigned OC_T3_US      = 6000;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } hcd_img_wr_type;

  typedef struct packed {
    logic       local_power_sense_pin;
    logic       port_led_support;
    logic       full_speed_only;
    logic       per_port_translator_en;
    logic       frame_end_packet_suppress;
    logic [1:0] overload_sense_mode;
    logic       power_switch_granularity;
    logic       dynamic_en;
    logic       compound;
  } hcd_opts_type;

endpackage : hcd_pkg

// ---- src/hcd_decoder.sv ----
`timescale 1ns/1ps
// Function
// - product id is byte 3 high, byte 2 low.
// - release id is byte 5 high, byte 4 low.
// - option1 bit 7 selects bus (0) or self (1) power.
// - with dynamic switching, local power sense pin decides power mode.
// - option1 bit 6 reports port led indicator support.
// - option1 bit 5 set forces full-speed only attach.
// - option1 bit 4 picks shared or per-port translators.
// - option1 bit 3 set suppresses end-of-packet at frame end.
// - option1 bits 2:1 pick ganged or per-port overload sensing.
// - option1 bit 0 picks ganged or per-port power switching.
// - option2 bit 7 enables auto fallback to bus power and back.
// - option2 bit 3 marks the hub as part of a compound device.
// - byte 8 bits 7:1 mark fixed ports; bit 0 reads zero.
// - byte 9 bits 7:1 disable ports when self powered; bit 0 zero.
// - with memory loading, image is read before attach.
module hcd_decoder
  import hcd_pkg::*;
#(
  parameter bit              DEFAULT_SELF = 1'b1,
  parameter bit              EEPROM_EN    = 1'b1,
  parameter logic [15:0]     DEFAULT_PID  = 16'h1234, // arbitrary value
  parameter int unsigned     OC_CYC_0     = OC_T0_US * 1000 / CLK_PERIOD_NS,
  parameter int unsigned     OC_CYC_1     = OC_T1_US * 1000 / CLK_PERIOD_NS,
  parameter int unsigned     OC_CYC_2     = OC_T2_US * 1000 / CLK_PERIOD_NS,
  parameter int unsigned     OC_CYC_3     = OC_T3_US * 1000 / CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                      REF_CLK,
  input  wire logic                      SRST,
  // image load port
  input  wire hcd_pkg::hcd_img_wr_type   IMG_WR,
  input  wire logic                      IMG_DONE,
  input  wire logic [hcd_pkg::ADDR_W-1:0] IMG_RD_ADDR,
  output logic [hcd_pkg::BYTE_W-1:0]     IMG_RDATA,
  // local power sense pin
  input  wire logic                      LOCAL_POWER_SENSE_PIN,
  // decoded configuration
  output logic [hcd_pkg::ID_W-1:0]       PRODUCT_ID,
  output logic [hcd_pkg::ID_W-1:0]       RELEASE_ID,
  output hcd_pkg::hcd_opts_type          OPTS,
  output logic [hcd_pkg::DLY_W-1:0]      OC_DELAY_CYCLES,
  output logic [hcd_pkg::BYTE_W-1:0]     FIXED_PORT_MASK,
  output logic [hcd_pkg::BYTE_W-1:0]     PORT_OFF,
  output logic                           ATTACH
);
  import hcd_pkg::*;

  // ****************************************************
  // state and storage
  // ****************************************************
  typedef enum logic [0:0] {ST_LOAD, ST_ATTACHED} hcd_state_type;

  localparam logic [7:0] RST_OPT1 = DEFAULT_SELF ? RST_OPT1_SELF
                                                 : RST_OPT1_BUS;
  localparam logic [7:0] RST_OPT2 = DEFAULT_SELF ? RST_OPT2_SELF
                                                 : RST_OPT2_BUS;

  hcd_state_type           state_ff, nxt_state;
  logic [ID_W-1:0]         pid_ff;
  logic [ID_W-1:0]         did_ff;
  logic [BYTE_W-1:0]       opt1_ff;
  logic [BYTE_W-1:0]       opt2_ff;
  logic [BYTE_W-1:0]       fixed_ff;
  logic [BYTE_W-1:0]       pdis_ff;
  logic [2:0]              sense_sync_ff;
  logic                    sensed_ff;
  logic [BYTE_W-1:0]       rdata_ff;
  logic [ID_W-1:0]         pid_out_ff;
  logic [ID_W-1:0]         did_out_ff;
  hcd_opts_type            opts_ff;
  logic [DLY_W-1:0]        dly_ff;
  logic [BYTE_W-1:0]       fixed_out_ff;
  logic [BYTE_W-1:0]       off_out_ff;
  logic                    attach_ff;

  // ****************************************************
  // decoding
  // ****************************************************
  // writes are only taken while loading, so options stay put
  wire wr_ok      = IMG_WR.we && (state_ff == ST_LOAD);
  wire wr_pid_lo  = wr_ok && (IMG_WR.addr == OFS_PID_LO);
  wire wr_pid_hi  = wr_ok && (IMG_WR.addr == OFS_PID_HI);
  wire wr_did_lo  = wr_ok && (IMG_WR.addr == OFS_DID_LO);
  wire wr_did_hi  = wr_ok && (IMG_WR.addr == OFS_DID_HI);
  wire wr_opt1    = wr_ok && (IMG_WR.addr == OFS_OPT1);
  wire wr_opt2    = wr_ok && (IMG_WR.addr == OFS_OPT2);
  wire wr_fixed   = wr_ok && (IMG_WR.addr == OFS_FIXED);
  wire wr_pdis    = wr_ok && (IMG_WR.addr == OFS_PDIS_SP);

  // reserved mask bit never stored as one
  wire [BYTE_W-1:0] mask_in = {IMG_WR.data[BYTE_W-1:1], 1'b0};

  wire dyn_en   = opt2_ff[OPT2_DYN];
  // dynamic mode ignores the option bit and follows the sensed pin
  wire self_eff = dyn_en ? sensed_ff
                         : opt1_ff[OPT1_PWR];

  wire [1:0] oct_sel = opt2_ff[OPT2_OCT_HI:OPT2_OCT_LO];
  wire [DLY_W-1:0] dly_sel =
    (oct_sel == OCT_0P1) ? DLY_W'(OC_CYC_0) :
    (oct_sel == OCT_2)   ? DLY_W'(OC_CYC_1) :
    (oct_sel == OCT_4)   ? DLY_W'(OC_CYC_2) :
                           DLY_W'(OC_CYC_3);

  // disable mask only counts in self-powered operation
  wire [BYTE_W-1:0] off_sel = self_eff ? pdis_ff
                                       : RST_MASK;

  // sensed pin level changes only when stages two and three agree
  wire sense_stable = (sense_sync_ff[1] == sense_sync_ff[2]);

  // attach waits for a complete image when memory loading is enabled
  wire load_done = !EEPROM_EN || IMG_DONE;

  // read mux: unmapped bytes read as zero
  wire [BYTE_W-1:0] rd_sel =
    (IMG_RD_ADDR == OFS_PID_LO)  ? pid_ff[BYTE_W-1:0]    :
    (IMG_RD_ADDR == OFS_PID_HI)  ? pid_ff[ID_W-1:BYTE_W] :
    (IMG_RD_ADDR == OFS_DID_LO)  ? did_ff[BYTE_W-1:0]    :
    (IMG_RD_ADDR == OFS_DID_HI)  ? did_ff[ID_W-1:BYTE_W] :
    (IMG_RD_ADDR == OFS_OPT1)    ? opt1_ff      :
    (IMG_RD_ADDR == OFS_OPT2)    ? opt2_ff      :
    (IMG_RD_ADDR == OFS_FIXED)   ? fixed_ff     :
    (IMG_RD_ADDR == OFS_PDIS_SP) ? pdis_ff      : RD_NONE;

  // ****************************************************
  // load sequencer
  // ****************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_LOAD: begin
        if (load_done) begin
          nxt_state = ST_ATTACHED;
        end
      end
      default: begin
        nxt_state = ST_ATTACHED;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_ff <= ST_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************
  // image bytes
  // ****************************************************
  // product and release ids are assembled high byte over low byte
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pid_ff <= DEFAULT_PID;
      did_ff <= RST_DID;
    end else begin
      if (wr_pid_lo) pid_ff[BYTE_W-1:0]    <= IMG_WR.data;
      if (wr_pid_hi) pid_ff[ID_W-1:BYTE_W] <= IMG_WR.data;
      if (wr_did_lo) did_ff[BYTE_W-1:0]    <= IMG_WR.data;
      if (wr_did_hi) did_ff[ID_W-1:BYTE_W] <= IMG_WR.data;
    end
  end

  // option and mask bytes
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      opt1_ff  <= RST_OPT1;
      opt2_ff  <= RST_OPT2;
      fixed_ff <= RST_MASK;
      pdis_ff  <= RST_MASK;
    end else begin
      if (wr_opt1)  opt1_ff  <= IMG_WR.data;
      if (wr_opt2)  opt2_ff  <= IMG_WR.data;
      if (wr_fixed) fixed_ff <= mask_in;
      if (wr_pdis)  pdis_ff  <= mask_in;
    end
  end

  // ****************************************************
  // local power sense synchroniser
  // ****************************************************
  // three stages; the first is read only by the second
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sense_sync_ff <= 3'h0;
      sensed_ff     <= 1'b0;
    end else begin
      sense_sync_ff <= {sense_sync_ff[1:0], LOCAL_POWER_SENSE_PIN};
      if (sense_stable) sensed_ff <= sense_sync_ff[2];
    end
  end

  // ****************************************************
  // registered outputs
  // ****************************************************
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pid_out_ff   <= DEFAULT_PID;
      did_out_ff   <= RST_DID;
      fixed_out_ff <= RST_MASK;
      off_out_ff   <= RST_MASK;
      dly_ff       <= DLY_W'(OC_CYC_1);
      rdata_ff     <= RD_NONE;
      attach_ff    <= 1'b0;
    end else begin
      pid_out_ff   <= pid_ff;
      did_out_ff   <= did_ff;
      fixed_out_ff <= fixed_ff;
      off_out_ff   <= off_sel;
      dly_ff       <= dly_sel;
      rdata_ff     <= rd_sel;
      attach_ff    <= (nxt_state == ST_ATTACHED);
    end
  end

  // option flags from every option1 bit, plus option2 bits 7 and 3
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      opts_ff <= '0;
    end else begin
      opts_ff.local_power_sense_pin                  <= self_eff;
      opts_ff.port_led_support          <= opt1_ff[OPT1_LED];
      opts_ff.full_speed_only           <= opt1_ff[OPT1_FSO];
      opts_ff.per_port_translator_en    <= opt1_ff[OPT1_MTT];
      opts_ff.frame_end_packet_suppress <= opt1_ff[OPT1_EOP];
      opts_ff.overload_sense_mode       <=
        opt1_ff[OPT1_OCS_HI:OPT1_OCS_LO];
      opts_ff.power_switch_granularity  <= opt1_ff[OPT1_PSW];
      opts_ff.dynamic_en                <= dyn_en;
      opts_ff.compound                  <= opt2_ff[OPT2_CMP];
    end
  end

  assign PRODUCT_ID      = pid_out_ff;
  assign RELEASE_ID      = did_out_ff;
  assign OPTS            = opts_ff;
  assign OC_DELAY_CYCLES = dly_ff;
  assign FIXED_PORT_MASK = fixed_out_ff;
  assign PORT_OFF        = off_out_ff;
  assign IMG_RDATA       = rdata_ff;
  assign ATTACH          = attach_ff;

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  sequence s_write_pid_hi;
    wr_pid_hi;
  endsequence

  sequence s_pid_seen;
    ##2 PRODUCT_ID[15:8] == $past(IMG_WR.data, 2);
  endsequence

  pid_assembly_a: assert property (
    s_write_pid_hi |-> s_pid_seen)
    else $error("product id high byte not taken from byte 3");

  did_assembly_a: assert property (
    wr_did_lo |-> ##2 RELEASE_ID[7:0] == $past(IMG_WR.data, 2))
    else $error("release id low byte not taken from byte 4");

  power_select_a: assert property (
    !dyn_en && $stable(opt1_ff) |=> OPTS.local_power_sense_pin == $past(opt1_ff[OPT1_PWR]))
    else $error("power mode does not follow option bit");

  dynamic_follow_a: assert property (
    dyn_en && $stable(dyn_en) |=> OPTS.local_power_sense_pin == $past(sensed_ff))
    else $error("dynamic power ignores sensed pin");

  sequence s_pin_steady;
    $stable(LOCAL_POWER_SENSE_PIN) [*4];
  endsequence

  pin_filter_a: assert property (
    s_pin_steady |=> sensed_ff == $past(LOCAL_POWER_SENSE_PIN, 2))
    else $error("sensed power level not settled after steady pin");

  speed_option_a: assert property (
    $stable(opt1_ff) |=> OPTS.full_speed_only == $past(opt1_ff[OPT1_FSO]))
    else $error("full speed only flag wrong");

  oc_delay_a: assert property (
    oct_sel == OCT_2 |=> OC_DELAY_CYCLES == DLY_W'(OC_CYC_1))
    else $error("overload delay code 01 wrong count");

  fixed_rsvd_a: assert property (
    FIXED_PORT_MASK[MASK_RSVD] == 1'b0 && PORT_OFF[MASK_RSVD] == 1'b0)
    else $error("reserved mask bit is set");

  bus_no_off_a: assert property (
    !self_eff |=> PORT_OFF == RST_MASK)
    else $error("ports disabled while bus powered");

  attach_wait_a: assert property (
    state_ff == ST_LOAD && !load_done |=> !ATTACH)
    else $error("attached before image complete");

  frozen_opts_a: assert property (
    ATTACH |=> $stable(opt1_ff) && $stable(pid_ff) && ATTACH)
    else $error("options changed after attach");

endmodule : hcd_decoder

// ---- test/hcd_img_src.sv ----
`timescale 1ns/1ps
// ****************************************************
// image source: serial memory or host feeding bytes
// ****************************************************
module hcd_img_src
  import hcd_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // control from the bench
  input  wire logic              start,
  input  wire logic              slow,
  input  wire logic [15:0][7:0]  img,
  // image port
  output hcd_pkg::hcd_img_wr_type wr,
  output logic                   done,
  output logic                   busy
);
  import hcd_pkg::*;

  hcd_img_wr_type wr_ff;
  logic           done_ff;
  logic           busy_ff;
  logic           gap_ff;
  logic [4:0]     idx_ff;

  assign wr   = wr_ff;
  assign done = done_ff;
  assign busy = busy_ff;

  // whole image, every offset, before done
  // idle data is inverted each cycle so a stale byte never looks valid
  always @(posedge clk) begin
    done_ff    <= 1'b0;
    wr_ff.we   <= 1'b0;
    wr_ff.data <= ~wr_ff.data;
    if (rst) begin
      busy_ff <= 1'b0;
      idx_ff  <= 5'h00;
      gap_ff  <= 1'b0;
      wr_ff   <= '0;
    end else if (start && !busy_ff) begin
      busy_ff <= 1'b1;
      idx_ff  <= 5'h00;
      gap_ff  <= 1'b0;
    end else if (busy_ff && slow && !gap_ff) begin
      gap_ff <= 1'b1; // slow memory: one idle cycle between bytes
    end else if (busy_ff && idx_ff < 5'h10) begin
      gap_ff <= 1'b0;
      wr_ff  <= {1'b1, idx_ff[3:0], img[idx_ff[3:0]]};
      idx_ff <= idx_ff + 5'h01;
    end else if (busy_ff) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b1;
    end
  end
endmodule : hcd_img_src

// ---- test/tb_hub_config_image_decoder.sv ----
`timescale 1ns/1ps
module tb_hub_config_image_decoder;
  import hcd_pkg::*;
  // short overload counts keep the run small
  localparam int unsigned OCC0 = 5;
  localparam int unsigned OCC1 = 10;
  localparam int unsigned OCC2 = 20;
  localparam int unsigned OCC3 = 30;

  logic             ref_clk = 1'b0;
  logic             srst    = 1'b1;
  logic [3:0]       rd_addr = 4'h0;
  logic             pin     = 1'b0;
  logic             start   = 1'b0;
  logic             slow    = 1'b0;
  logic [15:0][7:0] src_img = '0;
  logic [15:0][7:0] img;
  hcd_img_wr_type   img_wr;
  logic             img_done;
  logic             src_busy;
  logic [15:0]      product_identifier;
  logic [15:0]      rid;
  hcd_opts_type     opts;
  logic [20:0]      dly;
  logic [7:0]       rdata;
  logic [7:0]       fixed;
  logic [7:0]       poff;
  logic             attach;
  logic [15:0]      pid_b;
  logic [15:0]      rid_b;
  hcd_opts_type     opts_b;
  logic [20:0]      dly_b;
  logic [7:0]       fixed_b;
  logic [7:0]       poff_b;
  logic             attach_b;
  integer           seed = 32'ha7313019;
  int               n_errors = 0;
  int               checks = 0;

  // ****************************************************
  // clock, design and image source
  // ****************************************************
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  hcd_decoder #(.OC_CYC_0(OCC0), .OC_CYC_1(OCC1), .OC_CYC_2(OCC2),
    .OC_CYC_3(OCC3)) DUT (.REF_CLK(ref_clk), .SRST(srst),
    .IMG_WR(img_wr), .IMG_DONE(img_done), .IMG_RD_ADDR(rd_addr),
    .IMG_RDATA(rdata), .LOCAL_POWER_SENSE_PIN(pin), .PRODUCT_ID(product_identifier),
    .RELEASE_ID(rid), .OPTS(opts), .OC_DELAY_CYCLES(dly),
    .FIXED_PORT_MASK(fixed), .PORT_OFF(poff), .ATTACH(attach));

  // bus-powered defaults, no image memory: attaches straight after reset
  hcd_decoder #(.DEFAULT_SELF(1'b0), .EEPROM_EN(1'b0), .OC_CYC_0(OCC0),
    .OC_CYC_1(OCC1), .OC_CYC_2(OCC2), .OC_CYC_3(OCC3)) DUT_BUS (
    .REF_CLK(ref_clk), .SRST(srst), .IMG_WR(img_wr), .IMG_DONE(img_done),
    .IMG_RD_ADDR(rd_addr), .IMG_RDATA(), .LOCAL_POWER_SENSE_PIN(pin),
    .PRODUCT_ID(pid_b), .RELEASE_ID(rid_b), .OPTS(opts_b),
    .OC_DELAY_CYCLES(dly_b), .FIXED_PORT_MASK(fixed_b),
    .PORT_OFF(poff_b), .ATTACH(attach_b));

  hcd_img_src src (.clk(ref_clk), .rst(srst), .start(start),
    .slow(slow), .img(src_img), .wr(img_wr), .done(img_done),
    .busy(src_busy));

  // ****************************************************
  // expectations and compares
  // ****************************************************
  function automatic hcd_opts_type exp_opts(input logic [7:0] o1,
                                            input logic [7:0] o2,
                                            input logic p);
    logic s;
    s = o2[7] ? p : o1[7]; // sensed pin wins in dynamic mode
    return {s, o1[6:3], o1[2:1], o1[0], o2[7], o2[3]};
  endfunction : exp_opts

  function automatic logic [20:0] exp_dly(input logic [1:0] c);
    case (c)
      2'h0:    return OCC0[20:0];
      2'h1:    return OCC1[20:0];
      2'h2:    return OCC2[20:0];
      default: return OCC3[20:0];
    endcase
  endfunction : exp_dly

  function automatic logic [7:0] exp_rd(input logic [15:0][7:0] im,
                                        input int a);
    if (a >= 2 && a <= 7) return im[a];
    if (a == 8 || a == 9) return im[a] & 8'hFE;
    return 8'h00;
  endfunction : exp_rd

  task automatic note(input bit ok, input string m);
    checks++;
    if (!ok) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : note

  task automatic cmp_id(input logic [15:0] g, e, input string m);
    note(g === e, m);
  endtask : cmp_id

  task automatic cmp_byte(input logic [7:0] g, e, input string m);
    note(g === e, m);
  endtask : cmp_byte

  task automatic cmp_opts(input hcd_opts_type g, e, input string m);
    note(g === e, m);
  endtask : cmp_opts

  task automatic cmp_dly(input logic [20:0] g, e, input string m);
    note(g === e, m);
  endtask : cmp_dly

  task automatic end_of_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // every decoded output except ATTACH, then every offset through the read port
  task automatic check_all(input logic [15:0][7:0] im);
    hcd_opts_type eo;
    eo = exp_opts(im[6], im[7], pin);
    cmp_id(product_identifier, {im[3], im[2]}, "product id");
    cmp_id(rid, {im[5], im[4]}, "release id");
    cmp_opts(opts, eo, "options");
    cmp_dly(dly, exp_dly(im[7][5:4]), "overload delay");
    cmp_byte(fixed, im[8] & 8'hFE, "fixed ports");
    cmp_byte(poff, eo.local_power_sense_pin ? im[9] & 8'hFE : 8'h00,
             "port off");
    for (int a = 0; a < 16; a++) begin
      @(posedge ref_clk) rd_addr <= a[3:0];
      @(posedge ref_clk) #1;
      cmp_byte(rdata, exp_rd(im, a), "read back");
    end
  endtask : check_all

  // second instance keeps its defaults: every image write comes too late
  task automatic check_b;
    hcd_opts_type eo;
    eo = exp_opts(RST_OPT1_BUS, RST_OPT2_BUS, pin);
    cmp_byte({7'h00, attach_b}, 8'h01, "no memory attach");
    cmp_id(pid_b, 16'h1234, "default product id");
    cmp_id(rid_b, RST_DID, "default release id");
    cmp_opts(opts_b, eo, "bus defaults");
    cmp_dly(dly_b, exp_dly(RST_OPT2_BUS[5:4]), "default delay");
    cmp_byte(fixed_b, RST_MASK, "default fixed ports");
    cmp_byte(poff_b, RST_MASK, "default port off");
  endtask : check_b

  // bounded wait on a flag of the design or of the source
  task automatic wait_for(input bit want_attach);
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk) #1;
      if (want_attach && attach === 1'b1) return;
      if (!want_attach && src_busy === 1'b0) return;
    end
    note(1'b0, "wait ran out");
    end_of_test();
  endtask : wait_for

  task automatic load(input logic [15:0][7:0] im, input logic s);
    @(posedge ref_clk);
    src_img <= im;
    slow    <= s;
    start   <= 1'b1;
    @(posedge ref_clk) start <= 1'b0;
  endtask : load

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    logic [15:0][7:0] dflt;
    dflt    = '0;
    dflt[2] = 8'h34;
    dflt[3] = 8'h12;
    dflt[6] = RST_OPT1_SELF;
    dflt[7] = RST_OPT2_SELF;
    for (int r = 0; r < 6; r++) begin
      @(posedge ref_clk);
      srst <= 1'b1;
      pin  <= 1'($random(seed));
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      // every reset, first or mid-run, must bring the defaults back
      check_all(dflt);
      note(attach === 1'b0, "early attach");
      check_b();
      for (int i = 0; i < 16; i++) img[i] = 8'($random(seed));
      if (r == 0) img = '1; // every option set except the overload delay code
      if (r == 1) img = '0; // every option clear except the overload delay code
      img[7][5:4] = r[1:0]; // each overload delay code
      load(img, r[0]);
      wait_for(1'b1);
      repeat (8) @(posedge ref_clk);
      #1;
      check_all(img);
      load(~img, 1'b0); // late image must be ignored
      wait_for(1'b0);
      repeat (4) @(posedge ref_clk);
      #1;
      check_all(img);
      check_b();
      @(posedge ref_clk) pin <= ~pin;
      repeat (8) @(posedge ref_clk);
      #1;
      check_all(img);
      check_b();
    end
    end_of_test();
  end
endmodule : tb_hub_config_image_decoder
